// >>> rtl/cdt_timer.sv
// Contract
// - 32-bit counter decrements each clock while enabled; event at zero.
// - free-running mode reloads all ones at zero.
// - user mode reloads the reload value register at zero.
// - enabling the timer copies the reload value into the counter.
// - select bit 1 means user mode, 0 means free-running.
// - clearing enable resets the counter and its related state.
// - block bit 1 masks the interrupt, 0 leaves it unmasked.
// - interrupt asserts at zero in both modes when unmasked.
// - reading the acknowledge register clears the pending interrupt.
// - status output shows whether the interrupt is active.
// - disabling the timer clears a pending interrupt.
// - reset: disabled, unmasked, free-running, reload value zero.
// - set at zero wins over a coincident clear.
// - while enabled the interrupt holds until acknowledged; setting the block bit also drops timer_irq, while the pending flag stays set.
`timescale 1ns/100ps
`default_nettype none
`include "cdt_map.svh"

module cdt_timer
(
    // clock and reset
    input  wire logic                sys_clk,
    input  wire logic                reset,
    // control word write
    input  wire logic                ctrl_wr,
    input  wire cdt_pkg::cdt_ctrl_t  ctrl_wdata,
    // reload value write
    input  wire logic                reload_wr,
    input  wire cdt_pkg::cdt_count_t reload_wdata,
    // acknowledge read strobe
    input  wire logic                irq_ack_read,
    // status
    output var  cdt_pkg::cdt_ctrl_t  count_control_word,
    output var  cdt_pkg::cdt_count_t reload_value_register,
    output var  cdt_pkg::cdt_count_t current_count,
    output var  logic                irq_status,
    output var  logic                irq_raw_status,
    output var  logic                timer_irq
);
    import cdt_pkg::*;

    cdt_count_t count_w;
    logic       zero_w;
    logic       pend_w;
    logic       irq_w;

    ////////////////////////////////////////////////////////////////////
    // control word, reset to disabled, free-running, unmasked
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            count_control_word.count_run_bit     <= `CDT_RST_RUN;
            count_control_word.reload_select_bit <= `CDT_RST_SELECT;
            count_control_word.irq_block_bit     <= `CDT_RST_BLOCK;
        end
        else if (ctrl_wr)
            count_control_word <= ctrl_wdata;
    end

    ////////////////////////////////////////////////////////////////////
    // reload value register; software only writes it while disabled
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            reload_value_register <= `CDT_RST_RELOAD;
        else if (reload_wr)
            reload_value_register <= reload_wdata;
    end

    ////////////////////////////////////////////////////////////////////
    // counter core
    cdt_counter u_counter
    (
        .sys_clk      (sys_clk),
        .reset        (reset),
        .run          (count_control_word.count_run_bit),
        .user_mode    (count_control_word.reload_select_bit),
        .reload_value (reload_value_register),
        .count_r      (count_w),
        .zero_hit_r   (zero_w)
    );

    ////////////////////////////////////////////////////////////////////
    // interrupt flag and masked request
    cdt_irq u_irq
    (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .run       (count_control_word.count_run_bit),
        .zero_hit  (zero_w),
        .ack_read  (irq_ack_read),
        .block     (count_control_word.irq_block_bit),
        .pending_r (pend_w),
        .irq_r     (irq_w)
    );

    ////////////////////////////////////////////////////////////////////
    // registered copies of submodule flops
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            current_count <= `CDT_ZERO_COUNT;
        else
            current_count <= count_w;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            irq_status     <= 1'b0;
            irq_raw_status <= 1'b0;
            timer_irq      <= 1'b0;
        end
        else
        begin
            irq_status     <= irq_w;
            irq_raw_status <= pend_w;
            timer_irq      <= irq_w;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/cdt_map.svh
`ifndef CDT_MAP_SVH
`define CDT_MAP_SVH

// counter geometry
`define CDT_WIDTH        32
`define CDT_MAX_COUNT    32'hFFFFFFFF
`define CDT_ZERO_COUNT   32'h00000000
`define CDT_ONE_COUNT    32'h00000001

// reset values of the control word fields and the reload value
`define CDT_RST_RUN      1'b0
`define CDT_RST_SELECT   1'b0
`define CDT_RST_BLOCK    1'b0
`define CDT_RST_RELOAD   32'h00000000

// reload select encoding
`define CDT_SEL_FREE     1'b0
`define CDT_SEL_USER     1'b1

`endif

// >>> rtl/cdt_pkg.sv
`include "cdt_map.svh"

package cdt_pkg;

    typedef logic [`CDT_WIDTH-1:0] cdt_count_t;

    // control word as software sees it
    typedef struct packed {
        logic count_run_bit;
        logic reload_select_bit;
        logic irq_block_bit;
    } cdt_ctrl_t;

    // counter run phase
    typedef enum logic [1:0] {
        CDT_IDLE    = 2'h0,
        CDT_LOAD    = 2'h1,
        CDT_RUNNING = 2'h3
    } cdt_state_t;

endpackage

// >>> rtl/cdt_counter.sv
`timescale 1ns/100ps
`default_nettype none
`include "cdt_map.svh"

module cdt_counter
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset,
    // control
    input  wire logic              run,
    input  wire logic              user_mode,
    input  wire cdt_pkg::cdt_count_t reload_value,
    // status
    output var  cdt_pkg::cdt_count_t count_r,
    output var  logic              zero_hit_r
);
    import cdt_pkg::*;

    cdt_state_t state_r;
    cdt_count_t count_nxt;
    logic       zero_nxt;

    ////////////////////////////////////////////////////////////////////
    // next count: load on enable, decrement, reload at zero
    always_comb
    begin
        count_nxt = count_r;
        zero_nxt  = 1'b0;
        unique case (state_r)
            CDT_IDLE:
            begin
                count_nxt = `CDT_ZERO_COUNT;
                if (run)
                    count_nxt = reload_value;
            end
            CDT_LOAD, CDT_RUNNING:
            begin
                if (count_r == `CDT_ONE_COUNT || count_r == `CDT_ZERO_COUNT)
                begin
                    zero_nxt = 1'b1;
                    if (user_mode == `CDT_SEL_USER)
                        count_nxt = reload_value;
                    else
                        count_nxt = `CDT_MAX_COUNT;
                end
                else
                    count_nxt = count_r - `CDT_ONE_COUNT;
            end
            default:
                count_nxt = `CDT_ZERO_COUNT;
        endcase
        if (!run)
        begin
            count_nxt = `CDT_ZERO_COUNT;
            zero_nxt  = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // run phase
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            state_r <= CDT_IDLE;
        else if (!run)
            state_r <= CDT_IDLE;
        else if (state_r == CDT_IDLE)
            state_r <= CDT_LOAD;
        else
            state_r <= CDT_RUNNING;
    end

    ////////////////////////////////////////////////////////////////////
    // counter and zero strobe
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            count_r    <= `CDT_ZERO_COUNT;
            zero_hit_r <= 1'b0;
        end
        else
        begin
            count_r    <= count_nxt;
            zero_hit_r <= zero_nxt;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/cdt_irq.sv
`timescale 1ns/100ps
`default_nettype none
`include "cdt_map.svh"

module cdt_irq
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // events
    input  wire logic run,
    input  wire logic zero_hit,
    input  wire logic ack_read,
    input  wire logic block,
    // outputs
    output var  logic pending_r,
    output var  logic irq_r
);

    ////////////////////////////////////////////////////////////////////
    // sticky pending flag, set wins over clear
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            pending_r <= 1'b0;
        else if (!run)
            pending_r <= 1'b0;
        else if (zero_hit)
            pending_r <= 1'b1;
        else if (ack_read)
            pending_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // level interrupt request through the mask
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            irq_r <= 1'b0;
        else if (!run)
            irq_r <= 1'b0;
        else if (zero_hit && !block)
            irq_r <= 1'b1;
        else if (ack_read)
            irq_r <= 1'b0;
        else
            irq_r <= (pending_r && !block);
    end

endmodule

`default_nettype wire

// >>> verif/cdt_timer_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module cdt_timer_monitor
(
    // clock and reset
    input wire logic                sys_clk,
    input wire logic                reset,
    // block inputs
    input wire logic                ctrl_wr,
    input wire cdt_pkg::cdt_ctrl_t  ctrl_wdata,
    input wire logic                reload_wr,
    input wire cdt_pkg::cdt_count_t reload_wdata,
    input wire logic                irq_ack_read,
    // block outputs
    input wire cdt_pkg::cdt_ctrl_t  count_control_word,
    input wire cdt_pkg::cdt_count_t reload_value_register,
    input wire cdt_pkg::cdt_count_t current_count,
    input wire logic                irq_status,
    input wire logic                irq_raw_status,
    input wire logic                timer_irq
);
    import cdt_pkg::*;
    logic run;
    logic blk;
    // control fields pulled out of the word
    assign run = count_control_word.count_run_bit;
    assign blk = count_control_word.irq_block_bit;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // timer left running over the last four edges
    sequence s_steady;
        run && $past(run) && $past(run, 2) && $past(run, 3);
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_ctrl_word_load: assert property (ctrl_wr |=> count_control_word == $past(ctrl_wdata))
        else $error("control word not loaded");
    a_reload_reg_load: assert property (reload_wr |=> reload_value_register == $past(reload_wdata))
        else $error("reload value not loaded");
    a_count_step: assert property (s_steady ##0 $past(current_count) > 32'h1
        |-> current_count == $past(current_count) - 32'h1) else $error("count did not step down");
    a_free_reload: assert property (s_steady ##0 $past(current_count) == 32'h1 &&
        !count_control_word.reload_select_bit |-> current_count == 32'hFFFFFFFF) else $error("bad free reload");
    a_user_reload: assert property (s_steady ##0 $past(current_count) == 32'h1 &&
        count_control_word.reload_select_bit |-> current_count == reload_value_register) else $error("bad user reload");
    a_enable_load: assert property ($rose(run) |-> ##2 current_count == reload_value_register)
        else $error("enable did not load count");
    a_disable_clear: assert property (!run [*3] |-> !timer_irq && !irq_raw_status && current_count == 32'h0)
        else $error("disabled timer not cleared");
    a_irq_hold: assert property ($fell(timer_irq) |-> $past(irq_ack_read, 2) || !run || !$past(run) || blk || $past(blk))
        else $error("interrupt dropped without clear");
    a_mask_gate: assert property (blk [*3] |-> !timer_irq && !irq_status)
        else $error("masked interrupt visible");
    a_zero_raise: assert property (s_steady ##0 $past(current_count) == 32'h1 && !blk && !$past(blk) |=> timer_irq)
        else $error("no interrupt at zero");
    // main scenarios
    cover property ($rose(timer_irq));
    cover property (irq_ack_read && timer_irq);
    cover property ($fell(run));
endmodule
////////////////////////////////////////////////////////////////////////////////
bind cdt_timer cdt_timer_monitor i_mon (
    .sys_clk(sys_clk), .reset(reset), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .reload_wr(reload_wr), .reload_wdata(reload_wdata), .irq_ack_read(irq_ack_read),
    .count_control_word(count_control_word), .reload_value_register(reload_value_register),
    .current_count(current_count), .irq_status(irq_status), .irq_raw_status(irq_raw_status),
    .timer_irq(timer_irq));
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import cdt_pkg::*;
    // stimulus
    logic       sys_clk = 1'b0;
    logic       reset = 1'b1;
    logic       ctrl_wr = 1'b0;
    cdt_ctrl_t  ctrl_wdata = 3'h0;
    logic       reload_wr = 1'b0;
    cdt_count_t reload_wdata = 32'h0;
    logic       irq_ack_read = 1'b0;
    // observed outputs
    cdt_ctrl_t  count_control_word;
    cdt_count_t reload_value_register;
    cdt_count_t current_count;
    logic       irq_status;
    logic       irq_raw_status;
    logic       timer_irq;
    int         n_fail = 0;
    int         num_checks = 0;
    // 100 ns clock
    always #50 sys_clk = ~sys_clk;
    cdt_timer i_dut (
        .sys_clk(sys_clk), .reset(reset), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
        .reload_wr(reload_wr), .reload_wdata(reload_wdata), .irq_ack_read(irq_ack_read),
        .count_control_word(count_control_word), .reload_value_register(reload_value_register),
        .current_count(current_count), .irq_status(irq_status), .irq_raw_status(irq_raw_status),
        .timer_irq(timer_irq));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (n_fail == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #10;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_ctrl(input logic r, input logic s, input logic b);
        ctrl_wdata = {r, s, b};
        ctrl_wr = 1'b1;
        tick(1);
        ctrl_wr = 1'b0;
    endtask
    task automatic wr_reload(input logic [31:0] v);
        reload_wdata = v;
        reload_wr = 1'b1;
        tick(1);
        reload_wr = 1'b0;
    endtask
    // bounded wait for the interrupt line
    task automatic wait_irq();
        for (int i = 0; i < 60 && timer_irq !== 1'b1; i++)
            tick(1);
        if (timer_irq !== 1'b1)
        begin
            n_fail++;
            end_sim();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_user();
        wr_ctrl(1'b0, 1'b1, 1'b0);
        wr_reload(32'h14);
        wr_ctrl(1'b1, 1'b1, 1'b0);
        tick(2);
        chk(current_count, 32'h14);
        wait_irq();
        chk({irq_status, irq_raw_status}, 32'h3);
        irq_ack_read = 1'b1;
        tick(1);
        irq_ack_read = 1'b0;
        tick(2);
        chk({timer_irq, irq_status}, 32'h0);
        chk(current_count, 32'h10);
    endtask
    task automatic t_free();
        wr_ctrl(1'b0, 1'b0, 1'b0);
        wr_reload(32'h2);
        wr_ctrl(1'b1, 1'b0, 1'b0);
        tick(4);
        chk(current_count, 32'hFFFFFFFF);
        tick(1);
        chk(current_count, 32'hFFFFFFFE);
        chk(timer_irq, 32'h1);
    endtask
    task automatic t_disable();
        wr_ctrl(1'b0, 1'b0, 1'b0);
        tick(2);
        chk({timer_irq, irq_raw_status}, 32'h0);
        chk(current_count, 32'h0);
        // re-enable after a disable, as after a slow clock change
        wr_ctrl(1'b1, 1'b0, 1'b0);
        tick(2);
        chk(current_count, 32'h2);
    endtask
    task automatic t_coincide();
        wr_ctrl(1'b0, 1'b1, 1'b0);
        wr_reload(32'h0);
        wr_ctrl(1'b1, 1'b1, 1'b0);
        wait_irq();
        irq_ack_read = 1'b1;
        repeat (4)
        begin
            tick(1);
            chk(timer_irq, 32'h1);
        end
        irq_ack_read = 1'b0;
    endtask
    task automatic t_mask();
        wr_ctrl(1'b0, 1'b1, 1'b1);
        wr_reload(32'h4);
        wr_ctrl(1'b1, 1'b1, 1'b1);
        tick(12);
        chk({timer_irq, irq_status, irq_raw_status}, 32'h1);
        wr_ctrl(1'b1, 1'b1, 1'b0);
        tick(2);
        chk(timer_irq, 32'h1);
        reset = 1'b1;
        tick(1);
        reset = 1'b0;
        chk({count_control_word, reload_value_register}, 35'h0);
    endtask
    // main sequence
    initial
    begin
        tick(6);
        reset = 1'b0;
        chk({count_control_word, reload_value_register}, 35'h0);
        t_user();
        t_free();
        t_disable();
        t_coincide();
        t_mask();
        end_sim();
    end
endmodule
`default_nettype wire
